// [src/sfp_pkg.sv]
// constants and types shared by the stack, frame and programmed i/o unit
package sfp_pkg;
  // wishbone register byte offsets
  localparam logic [7:0] REG_INSTR = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [3:0] REG_ACC_PAGE = 4'h1;
  localparam logic [7:0] REG_SP = 8'h20;
  localparam logic [7:0] REG_FP = 8'h24;
  localparam logic [7:0] REG_PC = 8'h28;
  localparam logic [7:0] REG_CARRY = 8'h2C;
  // status register bit positions
  localparam int STB_BUSY = 0;
  localparam int STB_SKIP = 1;
  localparam int STB_OVF = 2;
  localparam int STB_BAD = 3;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [14:0] RST_PTR = 15'h0000;
  // instruction word fields, bit 0 of the word is the msb
  localparam logic [2:0] PIO_CLASS = 3'h3;
  localparam logic [5:0] DEV_CPU = 6'h01;
  localparam logic [5:0] DEV_RSV2 = 6'h02;
  localparam logic [5:0] DEV_RSV3 = 6'h03;
  localparam logic [5:0] DEV_CTRL = 6'h3F;
  // stack codes: {operation code, control field}
  localparam logic [4:0] STK_MOVE_TO_FRAME_PTR = 5'h00;
  localparam logic [4:0] STK_MOVE_FROM_FRAME_PTR = 5'h02;
  localparam logic [4:0] STK_MOVE_TO_STACK_PTR = 5'h08;
  localparam logic [4:0] STK_MOVE_FROM_STACK_PTR = 5'h0A;
  localparam logic [4:0] STK_PUSH = 5'h0C;
  localparam logic [4:0] STK_POP = 5'h0E;
  localparam logic [4:0] STK_SAVE = 5'h14;
  localparam logic [4:0] STK_RET = 5'h16;
  // programmed i/o operation codes
  localparam logic [2:0] IO_NIO = 3'h0;
  localparam logic [2:0] IO_DIA = 3'h1;
  localparam logic [2:0] IO_DIB = 3'h3;
  localparam logic [2:0] IO_DIC = 3'h5;
  localparam logic [2:0] IO_SKP = 3'h7;
  // skip test field codes
  localparam logic [1:0] SKT_BUSY_SET = 2'h0;
  localparam logic [1:0] SKT_BUSY_CLR = 2'h1;
  localparam logic [1:0] SKT_DONE_SET = 2'h2;
  // misc
  localparam logic [15:0] ABSENT_DATA = 16'hFFFF;
  localparam logic [7:0] SO_BOUNDARY = 8'h00;
  localparam logic [2:0] FRAME_LAST = 3'h4;
  typedef enum logic [3:0] {
    OP_NONE, OP_BAD, OP_MOVE_TO_FRAME_PTR, OP_MOVE_FROM_FRAME_PTR, OP_MOVE_TO_STACK_PTR, OP_MOVE_FROM_STACK_PTR,
    OP_PUSH, OP_POP, OP_SAVE, OP_RET, OP_IO
  } sfp_op_t;
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_EXEC = 5'b00010,
    S_MEM = 5'b00100,
    S_WAIT = 5'b01000,
    S_IO = 5'b10000
  } sfp_state_t;
endpackage

// [src/sfp_dec_if.sv]
// decoded instruction fields between the core and its decoder
`timescale 1ns/1ps
`default_nettype none
interface sfp_dec_if;
  import sfp_pkg::*;
  logic [15:0] instr;
  sfp_op_t op;
  logic [1:0] acsel;
  logic [2:0] io_op;
  logic [1:0] ctrl;
  modport core (output instr, input op, input acsel, input io_op, input ctrl);
  modport dec (input instr, output op, output acsel, output io_op, output ctrl);
endinterface
`default_nettype wire

// [src/sfp_decoder.sv]
// decoder of the i/o-format instruction word
`timescale 1ns/1ps
`default_nettype none
module sfp_decoder
  import sfp_pkg::*;
(
  sfp_dec_if.dec d
);
  logic [5:0] dev;
  logic [4:0] stk;
  assign dev = d.instr[5:0];
  assign stk = d.instr[10:6];
  assign d.acsel = d.instr[12:11];
  assign d.io_op = d.instr[10:8];
  assign d.ctrl = d.instr[7:6];

  // device code in bits 10-15, ac field bits 3-4, opcode, control bits 8-9
  always_comb
  begin
    d.op = OP_BAD;
    if (d.instr[15:13] == PIO_CLASS)
    begin
      if (dev == DEV_CPU)
      begin
        case (stk)
          STK_MOVE_TO_FRAME_PTR: d.op = OP_MOVE_TO_FRAME_PTR;
          STK_MOVE_FROM_FRAME_PTR: d.op = OP_MOVE_FROM_FRAME_PTR;
          STK_MOVE_TO_STACK_PTR: d.op = OP_MOVE_TO_STACK_PTR;
          STK_MOVE_FROM_STACK_PTR: d.op = OP_MOVE_FROM_STACK_PTR;
          STK_PUSH: d.op = OP_PUSH;
          STK_POP: d.op = OP_POP;
          STK_SAVE: d.op = (d.acsel == 2'h0) ? OP_SAVE : OP_BAD;
          STK_RET: d.op = (d.acsel == 2'h0) ? OP_RET : OP_BAD;
          default: d.op = OP_BAD;
        endcase
      end
      else if (dev == DEV_RSV2 || dev == DEV_RSV3)
        d.op = OP_BAD;
      else if (dev == DEV_CTRL)
        d.op = OP_NONE;
      else if ((d.io_op == IO_NIO || d.io_op == IO_SKP) && d.acsel != 2'h0)
        d.op = OP_BAD;
      else
        d.op = OP_IO;
    end
  end
endmodule
`default_nettype wire

// [src/sfp_unit.sv]
// stack, frame-save and programmed i/o execution unit with wishbone registers
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sfp_unit
  import sfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic mem_stb_o,
  output logic mem_we_o,
  output logic [14:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [15:0] mem_rdata_i,
  output logic io_stb_o,
  output logic [15:0] io_instr_o,
  output logic [15:0] io_wdata_o,
  input wire logic io_ack_i,
  input wire logic [15:0] io_rdata_i,
  input wire logic io_present_i,
  output logic so_req_o
);
  sfp_state_t state;
  logic [2:0] step;
  logic [15:0] cur_instr;
  logic [15:0] ac [4];
  logic [14:0] sp;
  logic [14:0] fp;
  logic [14:0] pc;
  logic carry;
  logic skip_flag;
  logic bad_flag;
  logic [14:0] next_sp;
  logic [15:0] push_word;
  logic [15:0] rd;
  logic [15:0] wmask;
  sfp_op_t op;
  logic [1:0] acsel;
  logic wb_hit, wb_wr, idle, start, issue, mem_done, io_done, last, fin, skip;
  logic io_input, dev_busy, dev_done;

  sfp_dec_if dif ();
  assign dif.instr = cur_instr;
  sfp_decoder u_dec (.d(dif.dec));
  assign op = dif.op;
  assign acsel = dif.acsel;

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_hit && wb_we_i;
  assign idle = (state == S_IDLE);
  assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign start = wb_wr && idle && wb_adr_i == REG_INSTR && wb_sel_i[1:0] == 2'h3;
  assign issue = (state == S_MEM);
  assign mem_done = (state == S_WAIT) && mem_ack_i;
  assign io_done = (state == S_IO) && io_ack_i;
  assign last = (op == OP_SAVE || op == OP_RET) ? (step == FRAME_LAST) : 1'b1;
  assign fin = (state == S_EXEC && op != OP_PUSH && op != OP_POP && op != OP_SAVE
                && op != OP_RET && op != OP_IO) || (mem_done && last) || io_done;
  assign io_input = dif.io_op == IO_DIA || dif.io_op == IO_DIB || dif.io_op == IO_DIC;
  // absent device flags read as 00; data bits 0/1 carry complemented done/busy
  assign dev_done = io_present_i && !io_rdata_i[15];
  assign dev_busy = io_present_i && !io_rdata_i[14];

  // skip decision from the test field
  always_comb
  begin
    skip = 1'b0;
    if (io_done && dif.io_op == IO_SKP)
    begin
      unique case (dif.ctrl)
        SKT_BUSY_SET: skip = dev_busy;
        SKT_BUSY_CLR: skip = !dev_busy;
        SKT_DONE_SET: skip = dev_done;
        default: skip = !dev_done;
      endcase
    end
  end

  // address of the next stack access, wrapping in fifteen bits
  always_comb
  begin
    next_sp = sp;
    if (op == OP_PUSH || op == OP_SAVE)
      next_sp = sp + 15'h0001;
    else if (op == OP_RET)
      next_sp = (step == 3'h0) ? fp : sp - 15'h0001;
  end

  // word written by push and by each save step
  always_comb
  begin
    push_word = ac[acsel];
    if (op == OP_SAVE)
    begin
      if (step == 3'h3)
        push_word = {1'b0, fp};
      else if (step == FRAME_LAST)
        push_word = {carry, ac[3][14:0]};
      else
        push_word = ac[step[1:0]];
    end
  end

  // sequencer and bus requests
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      step <= 3'h0;
      cur_instr <= RST_WORD;
      mem_stb_o <= 1'b0;
      mem_we_o <= 1'b0;
      mem_addr_o <= RST_PTR;
      mem_wdata_o <= RST_WORD;
      io_stb_o <= 1'b0;
      io_instr_o <= RST_WORD;
      io_wdata_o <= RST_WORD;
    end
    else
    begin
      unique case (state)
        S_IDLE:
          if (start)
          begin
            cur_instr <= wb_dat_i[15:0];
            state <= S_EXEC;
          end
        S_EXEC:
        begin
          step <= 3'h0;
          if (op == OP_PUSH || op == OP_POP || op == OP_SAVE || op == OP_RET)
            state <= S_MEM;
          else if (op == OP_IO)
          begin
            io_stb_o <= 1'b1;
            io_instr_o <= cur_instr;
            io_wdata_o <= ac[acsel];
            state <= S_IO;
          end
          else
            state <= S_IDLE;
        end
        S_MEM:
        begin
          mem_stb_o <= 1'b1;
          mem_we_o <= (op == OP_PUSH || op == OP_SAVE);
          mem_addr_o <= next_sp;
          mem_wdata_o <= push_word;
          state <= S_WAIT;
        end
        S_WAIT:
          if (mem_ack_i)
          begin
            mem_stb_o <= 1'b0;
            step <= step + 3'h1;
            state <= last ? S_IDLE : S_MEM;
          end
        S_IO:
          if (io_ack_i)
          begin
            io_stb_o <= 1'b0;
            state <= S_IDLE;
          end
      endcase
    end
  end

  // accumulators
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 4; i++)
        ac[i] <= RST_WORD;
    end
    else if (state == S_EXEC && op == OP_MOVE_FROM_STACK_PTR)
      ac[acsel] <= {1'b0, sp};
    else if (state == S_EXEC && op == OP_MOVE_FROM_FRAME_PTR)
      ac[acsel] <= {1'b0, fp};
    else if (mem_done && op == OP_POP)
      ac[acsel] <= mem_rdata_i;
    else if (mem_done && op == OP_SAVE && last)
      ac[3] <= {1'b0, sp};
    else if (mem_done && op == OP_RET && step != 3'h0)
      ac[2'(FRAME_LAST - step)] <= mem_rdata_i;
    else if (io_done && io_input)
      ac[acsel] <= io_present_i ? io_rdata_i : ABSENT_DATA;
    else if (wb_wr && idle && wb_adr_i[7:4] == REG_ACC_PAGE)
      ac[wb_adr_i[3:2]] <= (ac[wb_adr_i[3:2]] & ~wmask) | (wb_dat_i[15:0] & wmask);
  end

  // stack and frame pointers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sp <= RST_PTR;
      fp <= RST_PTR;
    end
    else
    begin
      if (issue && op != OP_POP)
        sp <= next_sp;
      else if (mem_done && (op == OP_POP || (op == OP_RET && last)))
        sp <= sp - 15'h0001;
      else if (state == S_EXEC && op == OP_MOVE_TO_STACK_PTR)
        sp <= ac[acsel][14:0];
      else if (wb_wr && idle && wb_adr_i == REG_SP)
        sp <= (sp & ~wmask[14:0]) | (wb_dat_i[14:0] & wmask[14:0]);
      if (mem_done && op == OP_SAVE && last)
        fp <= sp;
      else if (mem_done && op == OP_RET && last)
        fp <= ac[3][14:0];
      else if (state == S_EXEC && op == OP_MOVE_TO_FRAME_PTR)
        fp <= ac[acsel][14:0];
      else if (wb_wr && idle && wb_adr_i == REG_FP)
        fp <= (fp & ~wmask[14:0]) | (wb_dat_i[14:0] & wmask[14:0]);
    end
  end

  // program counter and carry; pointer wrap never reaches carry
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc <= RST_PTR;
      carry <= 1'b0;
    end
    else if (mem_done && op == OP_RET && step == 3'h0)
    begin
      carry <= mem_rdata_i[15];
      pc <= mem_rdata_i[14:0];
    end
    else if (fin && op != OP_RET)
      pc <= pc + (skip ? 15'h0002 : 15'h0001);
    else if (wb_wr && idle && wb_adr_i == REG_PC)
      pc <= (pc & ~wmask[14:0]) | (wb_dat_i[14:0] & wmask[14:0]);
    else if (wb_wr && idle && wb_adr_i == REG_CARRY && wb_sel_i[0])
      carry <= wb_dat_i[0];
  end

  // sticky overflow and bad flags, skip flag per instruction; a new event wins over a software clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      so_req_o <= 1'b0;
      bad_flag <= 1'b0;
      skip_flag <= 1'b0;
    end
    else
    begin
      if (issue && (op == OP_PUSH || op == OP_SAVE) && next_sp[7:0] == SO_BOUNDARY)
        so_req_o <= 1'b1;
      else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STB_OVF])
        so_req_o <= 1'b0;
      if (state == S_EXEC && op == OP_BAD)
        bad_flag <= 1'b1;
      else if (wb_wr && wb_adr_i == REG_STATUS && wb_sel_i[0] && wb_dat_i[STB_BAD])
        bad_flag <= 1'b0;
      if (fin)
        skip_flag <= skip;
    end
  end

  // register read mux
  always_comb
  begin
    rd = RST_WORD;
    if (wb_adr_i[7:4] == REG_ACC_PAGE)
      rd = ac[wb_adr_i[3:2]];
    else
    begin
      case (wb_adr_i)
        REG_INSTR: rd = cur_instr;
        REG_STATUS:
        begin
          rd[STB_BUSY] = !idle;
          rd[STB_SKIP] = skip_flag;
          rd[STB_OVF] = so_req_o;
          rd[STB_BAD] = bad_flag;
        end
        REG_SP: rd = {1'b0, sp};
        REG_FP: rd = {1'b0, fp};
        REG_PC: rd = {1'b0, pc};
        REG_CARRY: rd = {15'h0000, carry};
        default: rd = RST_WORD;
      endcase
    end
  end

  // wishbone answer, one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= {16'h0000, rd};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  push_incr_a: assert property (issue && op == OP_PUSH |=> mem_we_o && mem_addr_o == $past(sp) + 15'h0001 && sp == mem_addr_o) else $error("push address wrong");
  push_ovf_a: assert property (issue && op == OP_PUSH && next_sp[7:0] == SO_BOUNDARY |=> so_req_o) else $error("no overflow request");
  save_ovf_a: assert property (issue && op == OP_SAVE && sp[7:0] == 8'hFF |=> so_req_o) else $error("save overflow missed");
  pop_order_a: assert property (mem_done && op == OP_POP |=> sp == $past(sp) - 15'h0001 && ac[$past(acsel)] == $past(mem_rdata_i)) else $error("pop wrong");
  move_to_stack_ptr_copy_a: assert property (state == S_EXEC && op == OP_MOVE_TO_STACK_PTR |=> sp == $past(ac[acsel][14:0]) && ac[$past(acsel)] == $past(ac[acsel])) else $error("move to pointer wrong");
  move_from_stack_ptr_copy_a: assert property (state == S_EXEC && op == OP_MOVE_FROM_STACK_PTR |=> ac[$past(acsel)] == {1'b0, $past(sp)} && sp == $past(sp)) else $error("move from pointer wrong");
  save_fpword_a: assert property (issue && op == OP_SAVE && step == 3'h3 |=> mem_wdata_o == {1'b0, fp} && mem_we_o) else $error("saved frame word wrong");
  save_end_a: assert property (mem_done && op == OP_SAVE && last |=> fp == $past(sp) && ac[3] == {1'b0, $past(sp)}) else $error("save end wrong");
  ret_carry_a: assert property (mem_done && op == OP_RET && step == 3'h0 |=> carry == $past(mem_rdata_i[15]) && pc == $past(mem_rdata_i[14:0])) else $error("return carry wrong");
  ret_fp_a: assert property (mem_done && op == OP_RET && last |=> fp == $past(ac[3][14:0]) && sp == $past(sp) - 15'h0001) else $error("return end wrong");
  absent_read_a: assert property (io_done && io_input && !io_present_i |=> ac[$past(acsel)] == ABSENT_DATA) else $error("absent read wrong");
  carry_keep_a: assert property (issue && op == OP_SAVE |=> carry == $past(carry)) else $error("carry changed by save");
  save_done_c: cover property (mem_done && op == OP_SAVE && last);
  ret_done_c: cover property (mem_done && op == OP_RET && last);
  skip_taken_c: cover property (io_done && skip);
  overflow_c: cover property ($rose(so_req_o));
endmodule
`default_nettype wire

// [verif/sfp_far_model.sv]
// memory and i/o controller model on the far side of the unit
`timescale 1ns/1ps
`default_nettype none
module sfp_far_model
  import sfp_pkg::*;
(
  input wire logic clk_i,
  input wire logic slow_i,
  input wire logic mem_stb_i,
  input wire logic mem_we_i,
  input wire logic [14:0] mem_addr_i,
  input wire logic [15:0] mem_wdata_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  input wire logic io_stb_i,
  input wire logic [15:0] io_instr_i,
  input wire logic [15:0] io_wdata_i,
  output logic io_ack_o,
  output logic [15:0] io_rdata_o,
  output logic io_present_o
);
  // only device present; not a reserved code
  localparam logic [5:0] DEV_HERE = 6'h10;
  logic [15:0] mem [0:32767];
  logic [15:0] buf_q [0:3];
  logic [2:0] mcnt;
  logic [2:0] icnt;
  logic busy;
  logic done;
  logic [7:0] run;
  logic [2:0] op;
  logic here;
  assign op = io_instr_i[10:8];
  assign here = (io_instr_i[5:0] == DEV_HERE);
  initial
  begin
    mem_ack_o = 1'b0;
    mem_rdata_o = 16'h0000;
    io_ack_o = 1'b0;
    io_rdata_o = 16'h0000;
    io_present_o = 1'b0;
    mcnt = 3'h0;
    icnt = 3'h0;
    busy = 1'b0;
    done = 1'b0;
    run = 8'h00;
    buf_q[1] = 16'h0A0A;
    buf_q[2] = 16'h0B0B;
    buf_q[3] = 16'h0C0C;
  end
  // memory: one word per request, idle data lines keep toggling
  always @(posedge clk_i)
  begin
    if (mem_ack_o)
    begin
      mem_ack_o <= 1'b0;
      mcnt <= 3'h0;
      mem_rdata_o <= ~mem_rdata_o;
    end
    else if (mem_stb_i && mcnt >= (slow_i ? 3'h3 : 3'h0))
    begin
      mem_ack_o <= 1'b1;
      if (mem_we_i)
        mem[mem_addr_i] <= mem_wdata_i;
      mem_rdata_o <= mem[mem_addr_i];
    end
    else
    begin
      mcnt <= mcnt + (mem_stb_i ? 3'h1 : 3'h0);
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
  // controller: one word per instruction, then busy/done update
  always @(posedge clk_i)
  begin
    if (run != 8'h00)
      run <= run - 8'h01;
    if (run == 8'h01)
    begin
      busy <= 1'b0;
      done <= 1'b1;
    end
    if (io_ack_o)
    begin
      io_ack_o <= 1'b0;
      icnt <= 3'h0;
      io_rdata_o <= ~io_rdata_o;
    end
    else if (io_stb_i && icnt >= (slow_i ? 3'h2 : 3'h0))
    begin
      io_ack_o <= 1'b1;
      io_present_o <= here;
      if (!here)
        io_rdata_o <= ~io_rdata_o;
      else if (op == IO_SKP)
        io_rdata_o <= {~done, ~busy, 14'h0000};
      else
        io_rdata_o <= buf_q[(op + 3'h1) >> 1];
      if (here && op != IO_NIO && op[0] == 1'b0)
        buf_q[(op + 3'h1) >> 1] <= io_wdata_i;
      if (here && op != IO_SKP)
        case (io_instr_i[7:6])
          2'h1:
          begin
            busy <= 1'b1;
            done <= 1'b0;
            run <= 8'h96;
          end
          2'h2:
          begin
            busy <= 1'b0;
            done <= 1'b0;
            run <= 8'h00;
          end
          default:
          begin
          end
        endcase
    end
    else
    begin
      icnt <= icnt + (io_stb_i ? 3'h1 : 3'h0);
      io_rdata_o <= ~io_rdata_o;
    end
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking testbench of the stack, frame and i/o unit
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sfp_pkg::*;
;
  localparam logic [5:0] HERE = 6'h10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic mem_stb_o, mem_we_o, mem_ack_i, io_stb_o, io_ack_i, io_present_i, so_req_o;
  logic [14:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata_i, io_instr_o, io_wdata_o, io_rdata_i;
  int failures = 0;
  int samples_checked = 0;
  int io_count = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (io_stb_o === 1'b1 && io_ack_i === 1'b1)
      io_count++;
  sfp_unit sfp_unit_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h3), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_stb_o(mem_stb_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .io_stb_o(io_stb_o), .io_instr_o(io_instr_o),
    .io_wdata_o(io_wdata_o), .io_ack_i(io_ack_i), .io_rdata_i(io_rdata_i),
    .io_present_i(io_present_i), .so_req_o(so_req_o));
  sfp_far_model sfp_far_model_i (.clk_i(clk_i), .slow_i(slow), .mem_stb_i(mem_stb_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i), .io_stb_i(io_stb_o),
    .io_instr_i(io_instr_o), .io_wdata_i(io_wdata_o), .io_ack_o(io_ack_i),
    .io_rdata_o(io_rdata_i), .io_present_o(io_present_i));
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
    output logic [15:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 40);
    q = wb_dat_o[15:0];
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (n >= 40)
    begin
      failures++;
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [15:0] want);
    logic [15:0] q;
    wb(1'b0, a, 16'h0000, q);
    check(q, want);
  endtask
  function automatic logic [7:0] acc(input logic [1:0] n);
    return {REG_ACC_PAGE, n, 2'h0};
  endfunction
  function automatic logic [15:0] iw(input logic [1:0] ac, input logic [4:0] c,
    input logic [5:0] dev);
    return {PIO_CLASS, ac, c, dev};
  endfunction
  task automatic exec(input logic [15:0] ins);
    logic [15:0] s;
    int n;
    wr(REG_INSTR, ins);
    s = 16'h0001;
    n = 0;
    while (s[STB_BUSY] !== 1'b0 && n < 60)
    begin
      wb(1'b0, REG_STATUS, 16'h0000, s);
      n++;
    end
    if (n >= 60)
    begin
      failures++;
      test_done();
    end
  endtask
  // skip test per control code: advance of two words when the test holds
  task automatic skip_all(input logic [5:0] dev, input logic busy, input logic done);
    logic [15:0] p0;
    logic [15:0] p1;
    logic hit;
    for (int t = 0; t < 4; t++)
    begin
      hit = (t == 0) ? busy : (t == 1) ? !busy : (t == 2) ? done : !done;
      wb(1'b0, REG_PC, 16'h0000, p0);
      exec(iw(2'h0, {IO_SKP, 2'(t)}, dev));
      wb(1'b0, REG_PC, 16'h0000, p1);
      check(p1 - p0, hit ? 16'h0002 : 16'h0001);
    end
  endtask
  task automatic t_push_pop();
    wr(REG_CARRY, 16'h0001);
    wr(REG_SP, 16'h7FFE);
    wr(acc(1), 16'hBEEF);
    exec(iw(2'h1, STK_PUSH, DEV_CPU));
    check(sfp_far_model_i.mem[15'h7FFF], 16'hBEEF);
    check({15'h0000, so_req_o}, 16'h0000);
    wr(acc(1), 16'h1357);
    slow <= 1'b1;
    exec(iw(2'h1, STK_PUSH, DEV_CPU));
    check(sfp_far_model_i.mem[15'h0000], 16'h1357);
    chk_reg(REG_SP, 16'h0000);
    check({15'h0000, so_req_o}, 16'h0001);
    chk_reg(REG_CARRY, 16'h0001);
    chk_reg(acc(1), 16'h1357);
    exec(iw(2'h2, STK_POP, DEV_CPU));
    slow <= 1'b0;
    chk_reg(acc(2), 16'h1357);
    chk_reg(REG_SP, 16'h7FFF);
    wr(REG_STATUS, 16'h0004);
    chk_reg(REG_STATUS, 16'h0000);
  endtask
  task automatic t_moves();
    wr(acc(0), 16'h8123);
    exec(iw(2'h0, STK_MOVE_TO_STACK_PTR, DEV_CPU));
    chk_reg(REG_SP, 16'h0123);
    chk_reg(acc(0), 16'h8123);
    wr(acc(3), 16'hFFFF);
    exec(iw(2'h3, STK_MOVE_TO_FRAME_PTR, DEV_CPU));
    chk_reg(REG_FP, 16'h7FFF);
    exec(iw(2'h2, STK_MOVE_FROM_STACK_PTR, DEV_CPU));
    chk_reg(acc(2), 16'h0123);
    exec(iw(2'h1, STK_MOVE_FROM_FRAME_PTR, DEV_CPU));
    chk_reg(acc(1), 16'h7FFF);
    chk_reg(REG_FP, 16'h7FFF);
  endtask
  task automatic t_save_ret();
    wr(REG_SP, 16'h00FB);
    wr(REG_FP, 16'h1234);
    wr(REG_CARRY, 16'h0001);
    for (int i = 0; i < 4; i++)
      wr(acc(2'(i)), 16'(16'h1111 * (i + 1)));
    exec(iw(2'h0, STK_SAVE, DEV_CPU));
    for (int i = 0; i < 3; i++)
      check(sfp_far_model_i.mem[15'h00FC + i], 16'(16'h1111 * (i + 1)));
    check(sfp_far_model_i.mem[15'h00FF], 16'h1234);
    check(sfp_far_model_i.mem[15'h0100], 16'hC444);
    check({15'h0000, so_req_o}, 16'h0001);
    chk_reg(REG_FP, 16'h0100);
    chk_reg(acc(3), 16'h0100);
    for (int i = 0; i < 3; i++)
      wr(acc(2'(i)), 16'h0000);
    wr(REG_CARRY, 16'h0000);
    slow <= 1'b1;
    exec(iw(2'h0, STK_RET, DEV_CPU));
    slow <= 1'b0;
    chk_reg(REG_CARRY, 16'h0001);
    chk_reg(REG_PC, 16'h4444);
    chk_reg(acc(3), 16'h1234);
    for (int i = 0; i < 3; i++)
      chk_reg(acc(2'(i)), 16'(16'h1111 * (i + 1)));
    chk_reg(REG_SP, 16'h00FB);
    chk_reg(REG_FP, 16'h1234);
    wr(REG_STATUS, 16'h0004);
  endtask
  task automatic t_io();
    int n0;
    wr(acc(1), 16'h5A5A);
    exec(iw(2'h1, {3'h2, 2'h1}, HERE));
    check(sfp_far_model_i.buf_q[1], 16'h5A5A);
    skip_all(HERE, 1'b1, 1'b0);
    repeat (160) @(posedge clk_i);
    skip_all(HERE, 1'b0, 1'b1);
    exec(iw(2'h2, {IO_DIA, 2'h0}, HERE));
    chk_reg(acc(2), 16'h5A5A);
    exec(iw(2'h3, {IO_DIC, 2'h0}, HERE));
    chk_reg(acc(3), 16'h0C0C);
    skip_all(HERE, 1'b0, 1'b1);
    exec(iw(2'h0, {IO_NIO, 2'h2}, HERE));
    exec(iw(2'h0, {IO_NIO, 2'h3}, HERE));
    skip_all(HERE, 1'b0, 1'b0);
    n0 = io_count;
    exec(iw(2'h0, {IO_DIB, 2'h0}, 6'h20));
    chk_reg(acc(0), 16'hFFFF);
    check(16'(io_count - n0), 16'h0001);
    skip_all(6'h20, 1'b0, 1'b0);
  endtask
  task automatic t_bad();
    logic [15:0] p0;
    logic [15:0] bad [4];
    int n0;
    bad = '{iw(2'h0, {IO_DIA, 2'h0}, DEV_RSV2), iw(2'h1, {IO_NIO, 2'h0}, HERE),
      iw(2'h1, STK_SAVE, DEV_CPU), iw(2'h1, {IO_SKP, 2'h0}, HERE)};
    for (int i = 0; i < 4; i++)
    begin
      n0 = io_count;
      wb(1'b0, REG_PC, 16'h0000, p0);
      exec(bad[i]);
      chk_reg(REG_STATUS, 16'h0008);
      chk_reg(REG_PC, p0 + 16'h0001);
      check(16'(io_count - n0), 16'h0000);
      wr(REG_STATUS, 16'h0008);
    end
    n0 = io_count;
    wb(1'b0, REG_PC, 16'h0000, p0);
    exec(iw(2'h0, {IO_NIO, 2'h0}, DEV_CTRL));
    chk_reg(REG_PC, p0 + 16'h0001);
    check(16'(io_count - n0), 16'h0000);
    chk_reg(REG_STATUS, 16'h0000);
    chk_reg(8'h40, 16'h0000);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    check({15'h0000, so_req_o}, 16'h0000);
    t_push_pop();
    t_moves();
    t_save_ret();
    t_io();
    t_bad();
    test_done();
  end
endmodule
`default_nettype wire
